// ---- logic/exasf_top.sv ----
// extended add/subtract datapath holding the carry and zero flags
`timescale 1ns/1ps
`include "exasf_regs.svh"
module exasf_top #(parameter int WIDTH = `EXASF_WORD_BITS)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// instruction
	input wire logic op_valid_in,
	input wire exasf_pkg::exasf_op_t op_code_in,
	input wire logic [WIDTH-1:0] dest_in,
	input wire logic [WIDTH-1:0] src_in,
	input wire logic write_carry_effect_in,
	input wire logic write_zero_effect_in,
	// result and flags
	output logic [WIDTH-1:0] result_out,
	output logic result_valid_out,
	output logic carry_out,
	output logic zero_out
);
	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (WIDTH < `EXASF_MIN_BITS)
	begin : g_bad_width
		$error("exasf_top: WIDTH too small");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic [WIDTH-1:0] result;
		logic valid;
		logic carry;
		logic zero;
	} exasf_state_t;

	exasf_state_t state_reg;
	exasf_state_t state_next;

	exasf_alu_if #(.WIDTH(WIDTH)) alu ();

	exasf_core #(.WIDTH(WIDTH)) u_core
	(
		.alu(alu.calc)
	);

	assign alu.op = op_code_in;
	assign alu.a = dest_in;
	assign alu.b = src_in;
	// chained forms see the flags left by the previous instruction
	assign alu.cin = state_reg.carry;
	assign alu.zin = state_reg.zero;

	always_comb
	begin
		state_next = state_reg;
		state_next.valid = op_valid_in;
		if (op_valid_in)
		begin
			state_next.result = alu.res;
			if (write_carry_effect_in)
			begin
				state_next.carry = alu.cout;
			end
			if (write_zero_effect_in)
			begin
				state_next.zero = alu.zout;
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			state_reg.result <= '0;
			state_reg.valid <= `EXASF_VALID_RST;
			state_reg.carry <= `EXASF_CARRY_RST;
			state_reg.zero <= `EXASF_ZERO_RST;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign result_out = state_reg.result;
	assign result_valid_out = state_reg.valid;
	assign carry_out = state_reg.carry;
	assign zero_out = state_reg.zero;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// independent reference arithmetic, read only by the checks
	logic [WIDTH:0] h_uadd;
	logic [WIDTH:0] h_uaddx;
	logic [WIDTH:0] h_sadd;
	logic [WIDTH:0] h_usubx;
	logic [WIDTH:0] h_ssub;
	logic h_wc;
	logic h_wz;

	always_comb
	begin
		h_uadd = {1'b0, dest_in} + {1'b0, src_in};
		h_uaddx = h_uadd + {{WIDTH{1'b0}}, carry_out};
		h_sadd = {dest_in[WIDTH-1], dest_in} + {src_in[WIDTH-1], src_in} +
			{{WIDTH{1'b0}}, carry_out};
		h_usubx = {1'b0, dest_in} - {1'b0, src_in} -
			{{WIDTH{1'b0}}, carry_out};
		h_ssub = {dest_in[WIDTH-1], dest_in} - {src_in[WIDTH-1], src_in} -
			{{WIDTH{1'b0}}, carry_out};
		h_wc = op_valid_in && write_carry_effect_in;
		h_wz = op_valid_in && write_zero_effect_in;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	AST_ADD_RESULT: assert property (
		op_valid_in && op_code_in == exasf_pkg::EXASF_OP_ADD
		|=> result_valid_out && result_out == $past(h_uadd[WIDTH-1:0]))
		else $error("plain add result wrong");

	AST_ADD_CARRY: assert property (
		h_wc && op_code_in == exasf_pkg::EXASF_OP_ADD
		|=> carry_out == $past(h_uadd[WIDTH]))
		else $error("plain add carry wrong");

	AST_ADDX_CARRY: assert property (
		h_wc && op_code_in == exasf_pkg::EXASF_OP_ADDX
		|=> carry_out == $past(h_uaddx[WIDTH])
		&& result_out == $past(h_uaddx[WIDTH-1:0]))
		else $error("unsigned extended add wrong");

	AST_ADDSX_SIGN: assert property (
		h_wc && op_code_in == exasf_pkg::EXASF_OP_ADDSX
		|=> carry_out == $past(h_sadd[WIDTH]))
		else $error("signed extended add sign wrong");

	AST_EXT_ZERO: assert property (
		h_wz && (op_code_in == exasf_pkg::EXASF_OP_ADDX ||
		op_code_in == exasf_pkg::EXASF_OP_SUBX ||
		op_code_in == exasf_pkg::EXASF_OP_ADDSX ||
		op_code_in == exasf_pkg::EXASF_OP_SUBSX)
		|=> zero_out == ($past(zero_out) && result_out == '0))
		else $error("extended zero chaining wrong");

	AST_SUB_BORROW: assert property (
		h_wc && op_code_in == exasf_pkg::EXASF_OP_SUB
		|=> carry_out == ($past(dest_in) < $past(src_in)))
		else $error("plain subtract borrow wrong");

	AST_SUBX_BORROW: assert property (
		h_wc && op_code_in == exasf_pkg::EXASF_OP_SUBX
		|=> carry_out == $past(h_usubx[WIDTH])
		&& result_out == $past(h_usubx[WIDTH-1:0]))
		else $error("unsigned extended subtract wrong");

	AST_SUBSX_RESULT: assert property (
		op_valid_in && op_code_in == exasf_pkg::EXASF_OP_SUBSX
		|=> result_out == $past(h_ssub[WIDTH-1:0]))
		else $error("signed extended subtract result wrong");

	AST_SUBSX_SIGN: assert property (
		h_wc && op_code_in == exasf_pkg::EXASF_OP_SUBSX
		|=> carry_out == $past(h_ssub[WIDTH]))
		else $error("signed extended subtract sign wrong");

	AST_FLAGS_HOLD: assert property (
		!h_wc && !h_wz |=> $stable(carry_out) && $stable(zero_out))
		else $error("flags changed without effect");

	AST_PLAIN_ZERO: assert property (
		h_wz && (op_code_in == exasf_pkg::EXASF_OP_ADD ||
		op_code_in == exasf_pkg::EXASF_OP_SUB)
		|=> zero_out == (result_out == '0))
		else $error("plain zero flag wrong");

	// every taken instruction answers exactly one cycle later
	AST_VALID_PULSE: assert property (
		op_valid_in |=> result_valid_out)
		else $error("taken instruction gave no result");

	AST_VALID_IDLE: assert property (
		!op_valid_in |=> !result_valid_out && $stable(result_out))
		else $error("idle cycle changed the result");

	AST_SUB_RESULT: assert property (
		op_valid_in && op_code_in == exasf_pkg::EXASF_OP_SUB
		|=> result_out == $past(dest_in) - $past(src_in))
		else $error("plain subtract result wrong");

	AST_ADDX_RESULT: assert property (
		op_valid_in && op_code_in == exasf_pkg::EXASF_OP_ADDX
		|=> result_out == $past(h_uaddx[WIDTH-1:0]))
		else $error("unsigned extended add result wrong");

	AST_ADDSX_RESULT: assert property (
		op_valid_in && op_code_in == exasf_pkg::EXASF_OP_ADDSX
		|=> result_out == $past(h_sadd[WIDTH-1:0]))
		else $error("signed extended add result wrong");

	COV_ADD_SIGNED: cover property (
		h_wc && op_code_in == exasf_pkg::EXASF_OP_ADD ##1
		h_wc && op_code_in == exasf_pkg::EXASF_OP_ADDSX);

	COV_ADD_CHAIN: cover property (
		h_wc && op_code_in == exasf_pkg::EXASF_OP_ADD ##1
		h_wc && op_code_in == exasf_pkg::EXASF_OP_ADDX && carry_out);

	COV_SUB_SIGNED: cover property (
		h_wc && op_code_in == exasf_pkg::EXASF_OP_SUB ##1
		h_wc && op_code_in == exasf_pkg::EXASF_OP_SUBSX && carry_out);

	COV_ZERO_CHAIN: cover property (
		h_wz && op_code_in == exasf_pkg::EXASF_OP_SUB ##1
		h_wz && op_code_in == exasf_pkg::EXASF_OP_SUBX ##1 zero_out);
endmodule

// ---- logic/exasf_regs.svh ----
// constants of the extended add/subtract flag datapath
//
// Contract
// - 32-bit operands, chained low word first
// - plain add records unsigned carry-out
// - unsigned extended add: carry in, carry out
// - signed extended add: carry becomes result sign
// - extended forms: zero only if already zero
// - plain subtract records unsigned borrow
// - unsigned extended subtract: borrow in, out
// - signed extended subtract consumes borrow in
// - signed extended subtract: carry becomes sign
`ifndef EXASF_REGS_SVH
`define EXASF_REGS_SVH

`define EXASF_WORD_BITS 32
`define EXASF_MIN_BITS 2
`define EXASF_CARRY_RST 1'b0
`define EXASF_ZERO_RST 1'b0
`define EXASF_VALID_RST 1'b0

`endif

// ---- logic/exasf_pkg.sv ----
// types of the extended add/subtract flag datapath
package exasf_pkg;

	// ------------------------------------------------------------
	// operation codes
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		EXASF_OP_ADD,
		EXASF_OP_ADDX,
		EXASF_OP_ADDSX,
		EXASF_OP_SUB,
		EXASF_OP_SUBX,
		EXASF_OP_SUBSX
	} exasf_op_t;

endpackage

// ---- logic/exasf_alu_if.sv ----
// interface between flag datapath top and its arithmetic core
`timescale 1ns/1ps
`include "exasf_regs.svh"
interface exasf_alu_if #(parameter int WIDTH = `EXASF_WORD_BITS);
	exasf_pkg::exasf_op_t op;
	logic [WIDTH-1:0] a;
	logic [WIDTH-1:0] b;
	logic cin;
	logic zin;
	logic [WIDTH-1:0] res;
	logic cout;
	logic zout;

	modport requester
	(
		output op, a, b, cin, zin,
		input res, cout, zout
	);
	modport calc
	(
		input op, a, b, cin, zin,
		output res, cout, zout
	);
endinterface

// ---- logic/exasf_core.sv ----
// combinational add/subtract core with carry and zero chaining
`timescale 1ns/1ps
`include "exasf_regs.svh"
module exasf_core #(parameter int WIDTH = `EXASF_WORD_BITS)
(
	exasf_alu_if.calc alu
);
	// ------------------------------------------------------------
	// arithmetic
	// ------------------------------------------------------------
	function automatic logic is_extended(input exasf_pkg::exasf_op_t op);
		is_extended = (op == exasf_pkg::EXASF_OP_ADDX) ||
			(op == exasf_pkg::EXASF_OP_ADDSX) ||
			(op == exasf_pkg::EXASF_OP_SUBX) ||
			(op == exasf_pkg::EXASF_OP_SUBSX);
	endfunction

	logic [WIDTH:0] ua;
	logic [WIDTH:0] ub;
	logic [WIDTH:0] sa;
	logic [WIDTH:0] sb;
	logic [WIDTH:0] ci;
	logic [WIDTH:0] sum;
	logic ext;

	always_comb
	begin
		ext = is_extended(alu.op);
		ua = {1'b0, alu.a};
		ub = {1'b0, alu.b};
		sa = {alu.a[WIDTH-1], alu.a};
		sb = {alu.b[WIDTH-1], alu.b};
		// plain forms lead a chain, so the old carry is ignored
		ci = {{WIDTH{1'b0}}, ext & alu.cin};
		case (alu.op)
			exasf_pkg::EXASF_OP_ADD:
				sum = ua + ub;
			exasf_pkg::EXASF_OP_ADDX:
				sum = ua + ub + ci;
			exasf_pkg::EXASF_OP_ADDSX:
				sum = sa + sb + ci;
			exasf_pkg::EXASF_OP_SUB:
				sum = ua - ub;
			exasf_pkg::EXASF_OP_SUBX:
				sum = ua - ub - ci;
			exasf_pkg::EXASF_OP_SUBSX:
				sum = sa - sb - ci;
			default:
				sum = ua + ub;
		endcase
		// top bit is carry, borrow or true sign by operand extension
		alu.res = sum[WIDTH-1:0];
		alu.cout = sum[WIDTH];
		alu.zout = (sum[WIDTH-1:0] == '0) && (!ext || alu.zin);
	end
endmodule

// ---- bench/exasf_prog_model.sv ----
// instruction stream model feeding the flag datapath
`timescale 1ns/1ps
module exasf_prog_model
(
	// clock
	input wire logic clk_in,
	// instruction
	output logic op_valid_out,
	output exasf_pkg::exasf_op_t op_code_out,
	output logic [31:0] dest_out,
	output logic [31:0] src_out,
	output logic write_carry_effect_out,
	output logic write_zero_effect_out
);
	initial
	begin
		op_valid_out = 1'b0;
		op_code_out = exasf_pkg::EXASF_OP_ADD;
		dest_out = 32'h0;
		src_out = 32'h0;
		write_carry_effect_out = 1'b0;
		write_zero_effect_out = 1'b0;
	end

	// one instruction per call; chains go low word first
	task automatic issue(input logic v, input exasf_pkg::exasf_op_t op,
		input logic [31:0] a, input logic [31:0] b,
		input logic wc, input logic wz);
		@(posedge clk_in);
		op_valid_out <= v;
		op_code_out <= op;
		// idle operands toggle so no stale value looks meaningful
		dest_out <= v ? a : ~dest_out;
		src_out <= v ? b : ~src_out;
		write_carry_effect_out <= wc;
		write_zero_effect_out <= wz;
	endtask
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the extended add/subtract datapath
`timescale 1ns/1ps
module tb;
	logic clk_in, reset_in;
	wire logic v_w, wc_w, wz_w;
	wire exasf_pkg::exasf_op_t op_w;
	wire logic [31:0] a_w, b_w;
	logic [31:0] result_out;
	logic result_valid_out, carry_out, zero_out;
	int seed, bad_count, checked, k;
	logic c_exp, z_exp;
	logic [33:0] exp_q[$];
	logic [33:0] e;

	exasf_prog_model exasf_prog_model_inst (.clk_in(clk_in),
		.op_valid_out(v_w), .op_code_out(op_w), .dest_out(a_w),
		.src_out(b_w), .write_carry_effect_out(wc_w),
		.write_zero_effect_out(wz_w));
	exasf_top exasf_top_inst (.clk_in(clk_in), .reset_in(reset_in),
		.op_valid_in(v_w), .op_code_in(op_w), .dest_in(a_w),
		.src_in(b_w), .write_carry_effect_in(wc_w),
		.write_zero_effect_in(wz_w), .result_out(result_out),
		.result_valid_out(result_valid_out), .carry_out(carry_out),
		.zero_out(zero_out));

	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// own reference: 33-bit sum, sign-extended for the signed forms
	task automatic run(input logic v, input int op, input logic [31:0] a,
		input logic [31:0] b, input logic wc, input logic wz);
		logic [32:0] s, t;
		logic ext, sg, cin;
		ext = op inside {1, 2, 4, 5};
		sg = (op == 2) || (op == 5);
		cin = ext & c_exp;
		s = sg ? {a[31], a} : {1'b0, a};
		t = sg ? {b[31], b} : {1'b0, b};
		s = (op >= 3) ? s - t - cin : s + t + cin;
		if (v)
		begin
			if (wc)
				c_exp = s[32];
			if (wz)
				z_exp = (s[31:0] == 32'h0) & (!ext | z_exp);
			exp_q.push_back({s[31:0], c_exp, z_exp});
		end
		exasf_prog_model_inst.issue(v, exasf_pkg::exasf_op_t'(op), a, b, wc, wz);
	endtask

	// ------------------------------------------------------------
	// result watcher
	// ------------------------------------------------------------
	always @(posedge clk_in)
	begin
		#1;
		if (result_valid_out === 1'b1)
		begin
			check(32'(exp_q.size() != 0), 32'h1, "unexpected result");
			if (exp_q.size() != 0)
			begin
				e = exp_q.pop_front();
				check(result_out, e[33:2], "result");
				check({31'h0, carry_out}, {31'h0, e[1]}, "carry");
				check({31'h0, zero_out}, {31'h0, e[0]}, "zero");
			end
		end
	end

	initial
	begin
		#(1000 * 100);
		bad_count++;
		complete_run();
	end

	initial
	begin
		seed = 98;
		bad_count = 0;
		checked = 0;
		c_exp = 1'b0;
		z_exp = 1'b0;
		reset_in = 1'b1;
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		check(result_out, 32'h0, "reset result");
		check({29'h0, result_valid_out, carry_out, zero_out}, 32'h0,
			"reset flags");
		run(1, 0, 32'hffffffff, 32'h1, 1, 1);
		run(1, 1, 32'h0, 32'h0, 1, 1);
		run(0, 0, 32'h0, 32'h0, 0, 0);
		$display("test carry chain done");
		run(1, 3, 32'h1, 32'h2, 1, 1);
		run(1, 5, 32'h0, 32'h0, 1, 1);
		run(1, 0, 32'h0, 32'hffffffff, 1, 1);
		run(1, 2, 32'h1, 32'hffffffff, 1, 1);
		run(1, 4, 32'h0, 32'h0, 0, 0);
		$display("test signed chain done");
		repeat (400)
		begin
			k = $unsigned($random(seed)) % 6;
			run(($random(seed) & 3) != 0, k,
				($random(seed) & 3) ? $random(seed) : 32'h0,
				($random(seed) & 3) ? $random(seed) : 32'h0,
				1'($random(seed)), 1'($random(seed)));
		end
		// drop valid, else the last instruction is taken again
		run(0, 0, 32'h0, 32'h0, 0, 0);
		repeat (3) @(posedge clk_in);
		check(32'(exp_q.size()), 32'h0, "missing results");
		$display("test random stream done");
		complete_run();
	end
endmodule
